// ==== dv/lane_group_align_control_bench.sv ====
`timescale 1ns/1ps
////////////////////////////////////////
module lane_group_align_control_bench;
	import lane_align_pkg::*;

	logic              clk_in = 1'b0;
	logic              rst_n_in = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic              psel = 1'b0;
	logic              penable = 1'b0;
	logic              pwrite = 1'b0;
	logic [31:0]       pwdata = '0;
	logic [31:0]       prdata_out;
	logic              pready_out;
	logic              pslverr_out;
	logic              irq_out;
	logic [3:0]        ev = '0;
	logic [7:0]        pulses;
	blk_stat_t         stat_a, stat_b;
	blk_ctrl_t         ctrl_a_out, ctrl_b_out, c;
	int                fails = 0;
	int                cmp_count = 0;
	int                pc [8];
	int                seed = 32'hfcc30abd;
	logic [19:0]       ctl_i [8] = '{IDX_MEMBER_A, IDX_MODE_A, IDX_RESYNC_A, IDX_BYPASS_A,
		IDX_MEMBER_B, IDX_MODE_B, IDX_RESYNC_B, IDX_BYPASS_B};
	logic [7:0]        modes [4] = '{8'h00, 8'h0a, 8'h0f, 8'h00};

	lane_group_align_control DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .paddr_in(paddr),
		.psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata),
		.prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
		.stat_a_in(stat_a), .stat_b_in(stat_b), .ctrl_a_out(ctrl_a_out),
		.ctrl_b_out(ctrl_b_out), .irq_out(irq_out));
	lane_partner lanes (.clk_in(clk_in), .rst_n_in(rst_n_in), .ctrl_a_in(ctrl_a_out),
		.ctrl_b_in(ctrl_b_out), .ev_in(ev), .stat_a_out(stat_a), .stat_b_out(stat_b));

	initial begin
		forever #2.5 clk_in = ~clk_in;
	end

	// count pulse cycles: realign a c,d / resync a c,d / same for b
	assign pulses = {ctrl_b_out.lane_resync, ctrl_b_out.realign_pulse,
		ctrl_a_out.lane_resync, ctrl_a_out.realign_pulse};

	always @(posedge clk_in) begin
		for (int i = 0; i < 8; i++) begin
			if (pulses[i] === 1'b1) pc[i]++;
		end
	end

	////////////////////////////////////////
	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task finish_test;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : finish_test

	// one apb transfer; the request is held until pready is seen at an edge
	task apb(input logic [19:0] idx, input logic wr, input logic [7:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		@(posedge clk_in);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= {idx, 2'b00};
		pwrite <= wr;
		pwdata <= {24'h0, wd};
		@(posedge clk_in);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while (pready_out !== 1'b1 && n < 50);
		if (n >= 50) fails++;
		rd = prdata_out;
		err = pslverr_out;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wr(input logic [19:0] idx, input logic [7:0] d);
		logic [31:0] r;
		logic e;
		apb(idx, 1'b1, d, r, e);
	endtask : wr

	task rd(input logic [19:0] idx, input logic [7:0] exp, input logic experr);
		logic [31:0] r;
		logic e;
		apb(idx, 1'b0, 8'h00, r, e);
		check("read data", r, {24'h0, exp});
		check("slave error", e, experr);
	endtask : rd

	task pulse(input logic [19:0] idx, input logic [7:0] v, input logic [7:0] exp);
		pc = '{default: 0};
		wr(idx, v);
		repeat (4) @(posedge clk_in);
		for (int i = 0; i < 8; i++) check("pulse count", pc[i], {31'h0, exp[i]});
	endtask : pulse

	task event_pulse(input logic [3:0] e);
		@(posedge clk_in);
		ev <= e;
		@(posedge clk_in);
		ev <= 4'h0;
		repeat (3) @(posedge clk_in);
	endtask : event_pulse

	// a reset must leave every control cleared at the register and the port
	task reset_check;
		for (int i = 0; i < 8; i++) rd(ctl_i[i], 8'h00, 1'b0);
		check("ctrl a", ctrl_a_out, '0);
		check("ctrl b", ctrl_b_out, '0);
	endtask : reset_check

	function automatic logic [1:0] exp_mode(input logic [7:0] m);
		return (m == 8'h0a) ? 2'b01 : (m == 8'h0f) ? 2'b10 : 2'b00;
	endfunction : exp_mode

	////////////////////////////////////////
	// the whole run is well under 4000 cycles; this only cuts a hang
	initial begin
		repeat (20000) @(posedge clk_in);
		fails++;
		finish_test();
	end

	initial begin
		int b;
		logic [7:0] m, md;
		logic y;
		repeat (12) @(posedge clk_in);
		rst_n_in <= 1'b1;
		reset_check();
		pulse(IDX_MEMBER_A, 8'h04, 8'h01);
		pulse(IDX_MEMBER_A, 8'h0c, 8'h02);
		pulse(IDX_MEMBER_A, 8'h00, 8'h00);
		pulse(IDX_MEMBER_A, 8'h04, 8'h01);
		pulse(IDX_MEMBER_B, 8'h08, 8'h20);
		pulse(IDX_RESYNC_A, 8'h08, 8'h08);
		pulse(IDX_RESYNC_A, 8'h20, 8'h0c);
		pulse(IDX_RESYNC_A, 8'ha0, 8'h00);
		check("xaui a", ctrl_a_out.xaui_sel, 1'b1);
		rd(IDX_RESYNC_A, 8'ha0, 1'b0);
		pulse(IDX_RESYNC_B, 8'h04, 8'h40);
		check("xaui b", ctrl_b_out.xaui_sel, 1'b0);
		pulse(IDX_RESYNC_B, 8'h20, 8'hc0);
		wr(IDX_RESYNC_A, 8'h00);
		wr(IDX_RESYNC_B, 8'h00);
		rd(20'h30812, 8'h00, 1'b1);
		// random group setups with the three documented modes and a stray code
		for (int k = 0; k < 12; k++) begin
			b = $random(seed) & 1;
			m = $random(seed) & 8'hc3;
			md = (k % 4 == 3) ? 8'($random(seed)) : modes[k % 4];
			y = $random(seed) & 1;
			wr(ctl_i[b * 4], m);
			wr(ctl_i[b * 4 + 1], md);
			wr(ctl_i[b * 4 + 3], {7'h0, y});
			repeat (4) @(posedge clk_in);
			c = b ? ctrl_b_out : ctrl_a_out;
			rd(ctl_i[b * 4], m, 1'b0);
			rd(ctl_i[b * 4 + 1], md, 1'b0);
			check("member", c.group_member, m[7:6]);
			check("mode", c.mode, exp_mode(md));
			check("bypass", c.bypass, y);
			rd(b ? IDX_ALNSTAT_B : IDX_ALNSTAT_A,
				{(exp_mode(md) != 2'b00 && !y) ? m[7:6] : 2'b00, 6'h0}, 1'b0);
		end
		// sticky status flags, interrupt masking and clearing on read
		wr(IDX_IRQ_MASK, 8'h0f);
		event_pulse(4'b0001);
		check("irq raised", irq_out, 1'b1);
		rd(IDX_PAIRSTAT_A, 8'h02, 1'b0);
		rd(IDX_PAIRSTAT_A, 8'h00, 1'b0);
		rd(IDX_IRQ_STAT, 8'h01, 1'b0);
		repeat (3) @(posedge clk_in);
		check("irq cleared", irq_out, 1'b0);
		wr(IDX_IRQ_MASK, 8'h07);
		event_pulse(4'b1000);
		check("irq masked", irq_out, 1'b0);
		rd(IDX_PAIRSTAT_B, 8'h10, 1'b0);
		rd(IDX_IRQ_STAT, 8'h08, 1'b0);
		// a second reset in mid-run clears everything again
		@(posedge clk_in);
		rst_n_in <= 1'b0;
		repeat (3) @(posedge clk_in);
		rst_n_in <= 1'b1;
		reset_check();
		finish_test();
	end
endmodule : lane_group_align_control_bench

// ==== dv/lane_partner.sv ====
`timescale 1ns/1ps
////////////////////////////////////////
module lane_partner (
	input  wire logic                      clk_in,     // lane clock
	input  wire logic                      rst_n_in,   // async, active low
	input  wire lane_align_pkg::blk_ctrl_t ctrl_a_in,  // block a controls
	input  wire lane_align_pkg::blk_ctrl_t ctrl_b_in,  // block b controls
	input  wire logic [3:0]                ev_in,      // oos_b,ovfl_b,oos_a,ovfl_a
	output lane_align_pkg::blk_stat_t      stat_a_out, // block a status
	output lane_align_pkg::blk_stat_t      stat_b_out  // block b status
);
	import lane_align_pkg::*;

	// a lane counts as aligned only while grouped, in a sync mode and not
	// bypassed; a resync pulse knocks it out for a cycle like a real fifo
	function automatic logic [1:0] aligned(input blk_ctrl_t c);
		return c.group_member & {2{c.mode != ALIGN_NONE && !c.bypass}} & ~c.lane_resync;
	endfunction : aligned

	// fault events come only when the bench commands them
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			stat_a_out <= '0;
			stat_b_out <= '0;
		end else begin
			stat_a_out <= {aligned(ctrl_a_in), ev_in[0], ev_in[1]};
			stat_b_out <= {aligned(ctrl_b_in), ev_in[2], ev_in[3]};
		end
	end
endmodule : lane_partner

// ==== logic/lane_align_pkg.sv ====
package lane_align_pkg;
	// register indices; the byte address is four times the index (see reg_addr)
	localparam int unsigned N_IDX = 12;
	localparam logic [19:0] IDX_MEMBER_A   = 20'h30810;
	localparam logic [19:0] IDX_MODE_A     = 20'h30811;
	localparam logic [19:0] IDX_RESYNC_A   = 20'h30820;
	localparam logic [19:0] IDX_BYPASS_A   = 20'h30821;
	localparam logic [19:0] IDX_MEMBER_B   = 20'h30910;
	localparam logic [19:0] IDX_MODE_B     = 20'h30911;
	localparam logic [19:0] IDX_RESYNC_B   = 20'h30920;
	localparam logic [19:0] IDX_BYPASS_B   = 20'h30921;
	localparam logic [19:0] IDX_ALNSTAT_A  = 20'h30805;
	localparam logic [19:0] IDX_ALNSTAT_B  = 20'h30905;
	localparam logic [19:0] IDX_PAIRSTAT_A = 20'h30814;
	localparam logic [19:0] IDX_PAIRSTAT_B = 20'h30914;
	localparam logic [19:0] IDX_IRQ_STAT   = 20'h30a00;
	localparam logic [19:0] IDX_IRQ_MASK   = 20'h30a01;
	localparam int unsigned ADDR_W = 22;

	// field positions
	localparam int unsigned B_LANE_C    = 2;
	localparam int unsigned B_LANE_D    = 3;
	localparam int unsigned B_MEMBER_C  = 6;
	localparam int unsigned B_MEMBER_D  = 7;
	localparam int unsigned B_PAIR_RSY  = 5;
	localparam int unsigned B_XAUI      = 7;
	localparam int unsigned B_BYPASS    = 0;
	localparam int unsigned B_OVFL      = 1;
	localparam int unsigned B_OOS       = 4;
	localparam int unsigned B_ALIGNED_C = 6;
	localparam int unsigned B_ALIGNED_D = 7;
	localparam logic [7:0] MEMBER_WMASK = 8'hcf;

	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] MODE_NONE  = 8'h00;
	localparam logic [7:0] MODE_TWIN  = 8'h0a;
	localparam logic [7:0] MODE_QUAD  = 8'h0f;

	// interrupt status bit layout: per block, overflow and out of sync
	localparam int unsigned IRQ_W = 4;

	typedef enum logic [1:0] {
		ALIGN_NONE = 2'b00,
		ALIGN_TWIN = 2'b01,
		ALIGN_QUAD = 2'b10
	} align_mode_t;

	// per-block controls handed to the lane datapath
	typedef struct packed {
		logic [1:0]  realign_pulse;   // word realign, lanes d,c
		logic [1:0]  lane_resync;     // fifo pointer reset, lanes d,c
		logic [1:0]  group_member;    // lanes d,c
		align_mode_t mode;
		logic        xaui_sel;
		logic        bypass;
	} blk_ctrl_t;

	// per-block status from the lane datapath
	typedef struct packed {
		logic [1:0] aligned;   // lanes d,c
		logic       overflow;
		logic       out_of_sync;
	} blk_stat_t;

	// byte address of a register index
	function automatic logic [ADDR_W-1:0] reg_addr(input logic [19:0] idx);
		return {idx, 2'b00};
	endfunction : reg_addr
endpackage : lane_align_pkg

// ==== logic/lane_group_align_control.sv ====
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - realign word on request rising edge
// - member bit puts lane into group
// - mode byte selects none, twin, quad
// - lane resync edge resets fifo pointers
// - pair resync edge resyncs both lanes
// - xaui select overrides per-lane fsm select
// - bypass bit skips alignment fifos
// - all controls reset to zero
// - overflow, out-of-sync flags clear on read
// - per-lane aligned flag, zero after reset
module lane_group_align_control (
	input  wire logic                              clk_in,          // 200 mhz
	input  wire logic                              rst_n_in,        // async, active low
	input  wire logic [lane_align_pkg::ADDR_W-1:0] paddr_in,        // apb address
	input  wire logic                              psel_in,         // apb select
	input  wire logic                              penable_in,      // apb enable
	input  wire logic                              pwrite_in,       // apb direction
	input  wire logic [31:0]                       pwdata_in,       // apb write data
	output logic      [31:0]                       prdata_out,      // apb read data
	output logic                                   pready_out,      // apb ready
	output logic                                   pslverr_out,     // unmapped access
	input  wire lane_align_pkg::blk_stat_t         stat_a_in,       // block a lane status
	input  wire lane_align_pkg::blk_stat_t         stat_b_in,       // block b lane status
	output lane_align_pkg::blk_ctrl_t              ctrl_a_out,      // block a controls
	output lane_align_pkg::blk_ctrl_t              ctrl_b_out,      // block b controls
	output logic                                   irq_out          // level interrupt
);
	import lane_align_pkg::*;

	logic [7:0] member_q   [2];
	logic [7:0] mode_q     [2];
	logic [7:0] resync_q   [2];
	logic [7:0] bypass_q   [2];
	logic [7:0] member_p_q [2];  // previous values for edge detection
	logic [7:0] resync_p_q [2];
	logic [1:0] aligned_q  [2];
	logic       ovfl_q     [2];
	logic       oos_q      [2];
	logic [IRQ_W-1:0] irq_stat_q;
	logic [IRQ_W-1:0] irq_mask_q;
	logic [IRQ_W-1:0] irq_ev;
	blk_stat_t  stat   [2];
	blk_ctrl_t  ctrl_d [2];
	logic       setup, wr, rd, hit;
	logic [31:0] rdata_d;
	logic       rd_pstat [2];
	logic       rd_irq;

	assign stat[0] = stat_a_in;
	assign stat[1] = stat_b_in;

	////////////////////////////////////////////////////////////////////////////
	// apb: zero-wait answer, setup cycle decodes, access cycle commits
	assign setup = psel_in && !penable_in;
	assign wr    = psel_in && penable_in && pwrite_in;
	assign rd    = psel_in && penable_in && !pwrite_in;

	// decode the mode byte; unlisted codes behave as no alignment
	function automatic align_mode_t mode_dec(input logic [7:0] m);
		if (m == MODE_TWIN) return ALIGN_TWIN;
		else if (m == MODE_QUAD) return ALIGN_QUAD;
		else return ALIGN_NONE;
	endfunction : mode_dec

	// read mux and map hit
	always_comb begin
		rdata_d = 32'h0000_0000;
		hit     = 1'b1;
		if (paddr_in == reg_addr(IDX_MEMBER_A)) begin
			rdata_d[7:0] = member_q[0];
		end else if (paddr_in == reg_addr(IDX_MODE_A)) begin
			rdata_d[7:0] = mode_q[0];
		end else if (paddr_in == reg_addr(IDX_RESYNC_A)) begin
			rdata_d[7:0] = resync_q[0];
		end else if (paddr_in == reg_addr(IDX_BYPASS_A)) begin
			rdata_d[7:0] = bypass_q[0];
		end else if (paddr_in == reg_addr(IDX_MEMBER_B)) begin
			rdata_d[7:0] = member_q[1];
		end else if (paddr_in == reg_addr(IDX_MODE_B)) begin
			rdata_d[7:0] = mode_q[1];
		end else if (paddr_in == reg_addr(IDX_RESYNC_B)) begin
			rdata_d[7:0] = resync_q[1];
		end else if (paddr_in == reg_addr(IDX_BYPASS_B)) begin
			rdata_d[7:0] = bypass_q[1];
		end else if (paddr_in == reg_addr(IDX_ALNSTAT_A)) begin
			rdata_d[B_ALIGNED_D:B_ALIGNED_C] = aligned_q[0];
		end else if (paddr_in == reg_addr(IDX_ALNSTAT_B)) begin
			rdata_d[B_ALIGNED_D:B_ALIGNED_C] = aligned_q[1];
		end else if (paddr_in == reg_addr(IDX_PAIRSTAT_A)) begin
			rdata_d[B_OVFL] = ovfl_q[0];
			rdata_d[B_OOS]  = oos_q[0];
		end else if (paddr_in == reg_addr(IDX_PAIRSTAT_B)) begin
			rdata_d[B_OVFL] = ovfl_q[1];
			rdata_d[B_OOS]  = oos_q[1];
		end else if (paddr_in == reg_addr(IDX_IRQ_STAT)) begin
			rdata_d[IRQ_W-1:0] = irq_stat_q;
		end else if (paddr_in == reg_addr(IDX_IRQ_MASK)) begin
			rdata_d[IRQ_W-1:0] = irq_mask_q;
		end else begin
			hit = 1'b0;
		end
	end

	// data, ready and error registered in the setup cycle, so access ends at once
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			prdata_out  <= 32'h0000_0000;
			pready_out  <= 1'b0;
			pslverr_out <= 1'b0;
		end else begin
			pready_out  <= setup;
			pslverr_out <= setup && !hit;
			prdata_out  <= (setup && !pwrite_in) ? rdata_d : 32'h0000_0000;
		end
	end

	assign rd_pstat[0] = rd && paddr_in == reg_addr(IDX_PAIRSTAT_A);
	assign rd_pstat[1] = rd && paddr_in == reg_addr(IDX_PAIRSTAT_B);
	assign rd_irq      = rd && paddr_in == reg_addr(IDX_IRQ_STAT);

	////////////////////////////////////////////////////////////////////////////
	// control registers; reserved bits 4,5 of the member register stay zero
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			for (int b = 0; b < 2; b++) begin
				member_q[b] <= CTRL_RESET;
				mode_q[b]   <= CTRL_RESET;
				resync_q[b] <= CTRL_RESET;
				bypass_q[b] <= CTRL_RESET;
			end
		end else if (wr) begin
			if (paddr_in == reg_addr(IDX_MEMBER_A)) begin
				member_q[0] <= pwdata_in[7:0] & MEMBER_WMASK;
			end else if (paddr_in == reg_addr(IDX_MODE_A)) begin
				mode_q[0] <= pwdata_in[7:0];
			end else if (paddr_in == reg_addr(IDX_RESYNC_A)) begin
				resync_q[0] <= pwdata_in[7:0];
			end else if (paddr_in == reg_addr(IDX_BYPASS_A)) begin
				bypass_q[0] <= pwdata_in[7:0];
			end else if (paddr_in == reg_addr(IDX_MEMBER_B)) begin
				member_q[1] <= pwdata_in[7:0] & MEMBER_WMASK;
			end else if (paddr_in == reg_addr(IDX_MODE_B)) begin
				mode_q[1] <= pwdata_in[7:0];
			end else if (paddr_in == reg_addr(IDX_RESYNC_B)) begin
				resync_q[1] <= pwdata_in[7:0];
			end else if (paddr_in == reg_addr(IDX_BYPASS_B)) begin
				bypass_q[1] <= pwdata_in[7:0];
			end
		end
	end

	// previous request values; a held 1 issues nothing further
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			for (int b = 0; b < 2; b++) begin
				member_p_q[b] <= CTRL_RESET;
				resync_p_q[b] <= CTRL_RESET;
			end
		end else begin
			for (int b = 0; b < 2; b++) begin
				member_p_q[b] <= member_q[b];
				resync_p_q[b] <= resync_q[b];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// control outputs: rising-edge pulses plus steady levels
	always_comb begin
		for (int b = 0; b < 2; b++) begin
			ctrl_d[b].realign_pulse = member_q[b][B_LANE_D:B_LANE_C]
				& ~member_p_q[b][B_LANE_D:B_LANE_C];
			// pair resync hits both lanes, lane resync only its own
			ctrl_d[b].lane_resync = (resync_q[b][B_LANE_D:B_LANE_C]
				& ~resync_p_q[b][B_LANE_D:B_LANE_C])
				| {2{resync_q[b][B_PAIR_RSY] & ~resync_p_q[b][B_PAIR_RSY]}};
			ctrl_d[b].group_member = member_q[b][B_MEMBER_D:B_MEMBER_C];
			ctrl_d[b].mode         = mode_dec(mode_q[b]);
			ctrl_d[b].xaui_sel     = resync_q[b][B_XAUI];
			ctrl_d[b].bypass       = bypass_q[b][B_BYPASS];
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ctrl_a_out <= '0;
			ctrl_b_out <= '0;
		end else begin
			ctrl_a_out <= ctrl_d[0];
			ctrl_b_out <= ctrl_d[1];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// status flags: aligned follows the lane, pair flags are sticky, set beats read
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			for (int b = 0; b < 2; b++) begin
				aligned_q[b] <= 2'b00;
				ovfl_q[b]    <= 1'b0;
				oos_q[b]     <= 1'b0;
			end
		end else begin
			for (int b = 0; b < 2; b++) begin
				aligned_q[b] <= stat[b].aligned;
				ovfl_q[b] <= stat[b].overflow || (ovfl_q[b] && !rd_pstat[b]);
				oos_q[b] <= stat[b].out_of_sync || (oos_q[b] && !rd_pstat[b]);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupt: sticky events, clear on read, masked onto one level
	assign irq_ev = {stat[1].out_of_sync, stat[1].overflow,
		stat[0].out_of_sync, stat[0].overflow};

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			irq_stat_q <= '0;
			irq_mask_q <= '0;
			irq_out    <= 1'b0;
		end else begin
			irq_stat_q <= irq_ev | (rd_irq ? '0 : irq_stat_q);
			if (wr && paddr_in == reg_addr(IDX_IRQ_MASK))
				irq_mask_q <= pwdata_in[IRQ_W-1:0];
			irq_out <= |(irq_stat_q & irq_mask_q);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	sequence lane_req_rise(int b);
		!member_q[0][B_LANE_C] ##1 member_q[0][B_LANE_C];
	endsequence

	realign_pulse_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		lane_req_rise(0) |=> ctrl_a_out.realign_pulse[0] ##1 !ctrl_a_out.realign_pulse[0])
		else $error("realign pulse missing or too long");
	member_mask_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		member_q[0][5:4] == 2'b00 && member_q[1][5:4] == 2'b00)
		else $error("reserved member bits set");
	group_member_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		ctrl_b_out.group_member == $past(member_q[1][B_MEMBER_D:B_MEMBER_C]))
		else $error("group member output wrong");
	mode_quad_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		mode_q[0] == MODE_QUAD |=> ctrl_a_out.mode == ALIGN_QUAD)
		else $error("quad mode not decoded");
	mode_none_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(mode_q[1] != MODE_TWIN && mode_q[1] != MODE_QUAD) |=> ctrl_b_out.mode == ALIGN_NONE)
		else $error("undefined mode not none");
	lane_resync_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$rose(resync_q[1][B_LANE_D]) |=> ctrl_b_out.lane_resync[1])
		else $error("lane resync missing");
	pair_resync_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$rose(resync_q[0][B_PAIR_RSY]) |=> ctrl_a_out.lane_resync == 2'b11)
		else $error("pair resync missing");
	xaui_sel_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		resync_q[0][B_XAUI] |=> ctrl_a_out.xaui_sel)
		else $error("xaui select not passed");
	bypass_sel_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		ctrl_b_out.bypass == $past(bypass_q[1][B_BYPASS]))
		else $error("bypass not passed");
	ovfl_sticky_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		stat_a_in.overflow |=> ovfl_q[0] [*1] ##0 (ovfl_q[0] || !rd_pstat[0]))
		else $error("overflow flag not set");
	read_clear_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		rd_pstat[0] && !stat_a_in.out_of_sync |=> !oos_q[0])
		else $error("out of sync not cleared");
	aligned_track_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		stat_b_in.aligned[0] |=> aligned_q[1][0])
		else $error("aligned flag lost");
	apb_ready_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		setup |=> pready_out)
		else $error("apb ready late");
endmodule : lane_group_align_control
